// file: frt_pkg.sv
package frt_pkg;
	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_FAULT_CLEAR     = 8'h03;
	localparam logic [7:0]  CMD_TON_FAULT_ACT   = 8'h63;
	localparam logic [7:0]  CMD_TOFF_DELAY      = 8'h64;
	localparam logic [7:0]  CMD_TOFF_FALL       = 8'h65;
	localparam logic [7:0]  CMD_TOFF_WARN_LIM   = 8'h66;
	localparam logic [7:0]  CMD_POUT_WARN       = 8'h6a;
	localparam logic [7:0]  CMD_PIN_WARN        = 8'h6b;
	localparam logic [7:0]  CMD_TIME_UNIT       = 8'hd2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          ACT_RESP_HI         = 7;
	localparam int          ACT_RESP_LO         = 6;
	localparam int          ACT_RETRY_HI        = 5;
	localparam int          ACT_RETRY_LO        = 3;
	localparam int          ACT_TIME_HI         = 2;
	localparam int          ACT_TIME_LO         = 0;
	localparam int          LIN_EXP_HI          = 15;
	localparam int          LIN_EXP_LO          = 11;
	localparam int          LIN_MAN_HI          = 10;
	localparam int          LIN_FRAC            = 8;
	localparam int          VOUT_TARGET_SHIFT   = 3;

	// ----------------------------------------------------------------
	// encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_IGNORE         = 2'h0;
	localparam logic [1:0]  RESP_RUN_THEN_RETRY = 2'h1;
	localparam logic [1:0]  RESP_DISABLE_RETRY  = 2'h2;
	localparam logic [1:0]  RESP_LATCH_OFF      = 2'h3;
	localparam logic [2:0]  RETRY_NONE          = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER       = 3'h7;
	localparam logic [15:0] RST_WORD            = 16'h0000;
	localparam logic [7:0]  RST_ACTION          = 8'h00;
	localparam logic [7:0]  RST_TIME_UNIT       = 8'h01;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ             = 200;
	localparam int          MS_IN_US            = 1000;
	localparam int          CYC_PER_MS          = CLK_MHZ * MS_IN_US;

	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_ON    = 6'h02,
		ST_HOLD  = 6'h04,
		ST_RETRY = 6'h08,
		ST_LATCH = 6'h10,
		ST_DLY   = 6'h20
	} frt_state_t;
endpackage : frt_pkg

// file: frt_seq.sv
`timescale 1ns/10ps
// How it works
// RL1: retry codes 4,5,6 restart that often, then latch off until cleared.
// RL2: retry code 7 restarts forever until commanded off or another fault.
// RL3: restart starts are spaced by the retry time code interval in fault time units.
// RL4: three-bit time code gives two to the code time units.
// RL5: same interval is run-on time or restart spacing per response.
// RL6: time unit comes from the time-unit register at code 0xD2.
// RL7: turn-on timeout uses the output-voltage fault time unit.
// RL8: after disable, wait the linear millisecond turn-off delay before falling.
// RL9: after the delay, ramp output down over the linear fall time.
// RL10: warn if output stays above one eighth of set voltage past limit.
// RL11: warn when output power exceeds the linear output power threshold.
// RL12: warn when input power exceeds the linear input power threshold.
// RL13: disable-and-retry response shuts off at once, then follows retry setting.
// RL14: latched fault clears on clear command, off-on toggle, or bias loss.
// RL15: linear words are signed 5-bit exponent over signed 11-bit mantissa.
// RL16: host writes words to 16-bit settings and bytes to the action setting.
module frt_seq
	import frt_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// management command port
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic             rsp_valid_reg,
	output logic             rsp_nack_reg,
	output logic [15:0]      rsp_rdata_reg,
	// pins and converter status
	input  wire logic        ctrl_pin,
	input  wire logic        op_on,
	input  wire logic        ton_fault_pin,
	input  wire logic        other_fault_pin,
	input  wire logic [15:0] vout_set,
	input  wire logic [15:0] vout_meas,
	input  wire logic [15:0] pout_meas,
	input  wire logic [15:0] pin_meas,
	// converter control and flags
	output logic             out_en_reg,
	output logic             fall_active_reg,
	output logic             retry_wait_reg,
	output logic             fault_latched_reg,
	output logic             toff_warn_reg,
	output logic             pout_warn_reg,
	output logic             pin_warn_reg
);
	// divider needs a count of two or more
	if (CYC_MS < 2) begin : g_bad_cyc
		$error("frt_seq: CYC_MS must be at least 2");
	end

	// ----------------------------------------------------------------
	// linear format
	// ----------------------------------------------------------------
	function automatic logic [39:0] lin_q8(input logic [15:0] v);
		logic signed [5:0] e;
		logic [39:0]       m;
		logic [5:0]        ne;
		e  = 6'($signed(v[LIN_EXP_HI:LIN_EXP_LO]));
		ne = 6'(-e);
		m  = {29'h0, v[LIN_MAN_HI:0]} << LIN_FRAC;
		// negative mantissa treated as zero: no negative times or power
		if (v[LIN_MAN_HI])
			m = 40'h0;
		if (e < 0)
			lin_q8 = m >> ne; // RL15
		else
			lin_q8 = m << e[4:0]; // RL15
	endfunction : lin_q8

	function automatic logic [31:0] lin_ms(input logic [15:0] v);
		logic [39:0] q;
		q = lin_q8(v) >> LIN_FRAC;
		lin_ms = (q[39:32] != 8'h00) ? 32'hffff_ffff : q[31:0];
	endfunction : lin_ms

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_raw;
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] flt_reg;

	assign pin_raw = {other_fault_pin, ton_fault_pin, ctrl_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					s1_reg[gi]  <= 1'b0;
					s2_reg[gi]  <= 1'b0;
					s3_reg[gi]  <= 1'b0;
					flt_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					// change accepted once two stages agree
					if (s2_reg[gi] == s3_reg[gi])
						flt_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	logic ctrl_ok;
	logic ton_flt;
	logic oth_flt;
	logic       on_req;
	logic       ton_q;
	logic       ton_evt;
	frt_state_t state;
	frt_state_t state_next;

	assign ctrl_ok = flt_reg[0];
	assign ton_flt = flt_reg[1];
	assign oth_flt = flt_reg[2];
	assign on_req  = ctrl_ok & op_on;
	assign ton_evt = ton_flt & ~ton_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ton_q <= 1'b0;
		end else begin
			// re-armed per attempt so a fault still held fails the restart
			ton_q <= ton_flt && (state == ST_ON);
		end
	end

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	logic [15:0] toff_delay_reg;
	logic [15:0] toff_fall_reg;
	logic [15:0] toff_lim_reg;
	logic [15:0] pout_thr_reg;
	logic [15:0] pin_thr_reg;
	logic [7:0]  action_reg;
	logic [7:0]  unit_reg;
	logic        clr_cmd;
	logic        wr;

	assign wr      = cmd_valid & cmd_write;
	assign clr_cmd = wr & (cmd_code == CMD_FAULT_CLEAR);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toff_delay_reg <= RST_WORD;
			toff_fall_reg  <= RST_WORD;
			toff_lim_reg   <= RST_WORD;
			pout_thr_reg   <= RST_WORD;
			pin_thr_reg    <= RST_WORD;
			action_reg     <= RST_ACTION;
			unit_reg       <= RST_TIME_UNIT;
		end else if (wr) begin
			case (cmd_code) // RL16
				CMD_TOFF_DELAY:    toff_delay_reg <= cmd_wdata;
				CMD_TOFF_FALL:     toff_fall_reg  <= cmd_wdata;
				CMD_TOFF_WARN_LIM: toff_lim_reg   <= cmd_wdata;
				CMD_POUT_WARN:     pout_thr_reg   <= cmd_wdata;
				CMD_PIN_WARN:      pin_thr_reg    <= cmd_wdata;
				CMD_TON_FAULT_ACT: action_reg     <= cmd_wdata[7:0];
				CMD_TIME_UNIT:     unit_reg       <= cmd_wdata[7:0]; // RL6
				default:           ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;
	logic        rd_hit;

	always_comb begin
		rd_hit = 1'b1;
		case (cmd_code)
			CMD_TOFF_DELAY:    rd_mux = toff_delay_reg;
			CMD_TOFF_FALL:     rd_mux = toff_fall_reg;
			CMD_TOFF_WARN_LIM: rd_mux = toff_lim_reg;
			CMD_POUT_WARN:     rd_mux = pout_thr_reg;
			CMD_PIN_WARN:      rd_mux = pin_thr_reg;
			CMD_TON_FAULT_ACT: rd_mux = {8'h00, action_reg};
			CMD_TIME_UNIT:     rd_mux = {8'h00, unit_reg};
			default: begin
				rd_mux = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
		if (cmd_write)
			rd_hit = rd_hit | (cmd_code == CMD_FAULT_CLEAR);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid_reg <= 1'b0;
			rsp_nack_reg  <= 1'b0;
			rsp_rdata_reg <= 16'h0000;
		end else begin
			rsp_valid_reg <= cmd_valid;
			rsp_nack_reg  <= cmd_valid & ~rd_hit;
			if (cmd_valid & ~cmd_write)
				rsp_rdata_reg <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// millisecond tick and retry interval
	// ----------------------------------------------------------------
	logic [31:0] div_cnt;
	logic        ms_tick;
	logic [7:0]  units;
	logic [15:0] interval_ms;

	assign ms_tick = (div_cnt == 32'(CYC_MS - 1));
	// vout fault unit drives this fault too; zero unit read as one
	assign units = 8'h01 << action_reg[ACT_TIME_HI:ACT_TIME_LO]; // RL4
	assign interval_ms = 16'(units) *
		16'((unit_reg == 8'h00) ? 8'h01 : unit_reg); // RL7

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			div_cnt <= 32'h0;
		else if (ms_tick)
			div_cnt <= 32'h0;
		else
			div_cnt <= div_cnt + 32'h1;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	logic [31:0] tmr_ms;
	logic [15:0] att_ms;
	logic [2:0]  att_cnt;
	logic        fall_ph;
	logic        fall_ph_next;
	logic        att_inc;
	logic [1:0]  resp;
	logic [2:0]  rtry;
	logic        retry_go;

	assign resp = action_reg[ACT_RESP_HI:ACT_RESP_LO];
	assign rtry = action_reg[ACT_RETRY_HI:ACT_RETRY_LO];
	// code 7 never runs out; codes 1 to 6 bound the attempts
	assign retry_go = (rtry == RETRY_FOREVER) ||
		((rtry != RETRY_NONE) && (att_cnt < rtry)); // RL1 RL2

	always_comb begin
		state_next   = state;
		fall_ph_next = fall_ph;
		att_inc      = 1'b0;
		case (state)
			ST_OFF: begin
				if (on_req)
					state_next = ST_ON;
			end
			ST_ON: begin
				if (!on_req) begin
					state_next   = ST_DLY; // RL8
					fall_ph_next = 1'b0;
				end else if (oth_flt)
					state_next = ST_LATCH;
				else if (ton_evt) begin
					case (resp)
						RESP_IGNORE:         state_next = ST_ON;
						RESP_RUN_THEN_RETRY: state_next = ST_HOLD; // RL5
						RESP_DISABLE_RETRY: begin
							state_next = retry_go ? ST_RETRY : ST_LATCH; // RL13
							att_inc    = retry_go;
						end
						default:             state_next = ST_LATCH;
					endcase
				end
			end
			ST_HOLD: begin
				if (!on_req) begin
					state_next   = ST_DLY;
					fall_ph_next = 1'b0;
				end else if (oth_flt)
					state_next = ST_LATCH;
				else if (ms_tick && (tmr_ms + 32'h1 >= 32'(interval_ms))) begin
					if (!ton_flt)
						state_next = ST_ON;
					else begin
						state_next = retry_go ? ST_RETRY : ST_LATCH; // RL1
						att_inc    = retry_go;
					end
				end
			end
			ST_RETRY: begin
				if (!on_req)
					state_next = ST_OFF; // RL2
				else if (oth_flt)
					state_next = ST_LATCH; // RL2
				else if (att_ms >= interval_ms)
					state_next = ST_ON; // RL3
			end
			ST_LATCH: begin
				if (clr_cmd || !on_req)
					state_next = ST_OFF; // RL14
			end
			ST_DLY: begin
				if (!fall_ph && tmr_ms >= lin_ms(toff_delay_reg))
					fall_ph_next = 1'b1; // RL9
				else if (fall_ph && tmr_ms >= lin_ms(toff_fall_reg))
					state_next = ST_OFF; // RL9
			end
			default: state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state   <= ST_OFF;
			fall_ph <= 1'b0;
		end else begin
			state   <= state_next;
			fall_ph <= fall_ph_next;
		end
	end

	// phase timer restarts on every state or phase change
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tmr_ms <= 32'h0;
		else if (state_next != state || fall_ph_next != fall_ph)
			tmr_ms <= 32'h0;
		else if (ms_tick && tmr_ms != 32'hffff_ffff)
			tmr_ms <= tmr_ms + 32'h1;
	end

	// attempt timer runs from the start of each attempt
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			att_ms <= 16'h0;
		else if (state != ST_ON && state_next == ST_ON)
			att_ms <= 16'h0; // RL3
		else if (ms_tick && att_ms != 16'hffff)
			att_ms <= att_ms + 16'h1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			att_cnt <= 3'h0;
		else if (state == ST_OFF || clr_cmd)
			att_cnt <= 3'h0;
		else if (att_inc && att_cnt != RETRY_FOREVER)
			att_cnt <= att_cnt + 3'h1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_en_reg        <= 1'b0;
			fall_active_reg   <= 1'b0;
			retry_wait_reg    <= 1'b0;
			fault_latched_reg <= 1'b0;
		end else begin
			out_en_reg <= (state_next == ST_ON) || (state_next == ST_HOLD) ||
				(state_next == ST_DLY);
			fall_active_reg   <= (state_next == ST_DLY) && fall_ph_next;
			retry_wait_reg    <= (state_next == ST_RETRY);
			fault_latched_reg <= (state_next == ST_LATCH);
		end
	end

	// ----------------------------------------------------------------
	// warnings
	// ----------------------------------------------------------------
	logic [39:0] vout_tgt;
	logic [31:0] pd_ms;
	logic        pd_active;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vout_tgt  <= 40'h0;
			pd_active <= 1'b0;
			pd_ms     <= 32'h0;
		end else begin
			if (state == ST_ON && state_next == ST_DLY) begin
				vout_tgt  <= lin_q8(vout_set) >> VOUT_TARGET_SHIFT; // RL10
				pd_active <= 1'b1;
				pd_ms     <= 32'h0;
			end else if (pd_active) begin
				if (on_req || lin_q8(vout_meas) <= vout_tgt)
					pd_active <= 1'b0;
				else if (ms_tick && pd_ms != 32'hffff_ffff)
					pd_ms <= pd_ms + 32'h1;
			end
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toff_warn_reg <= 1'b0;
			pout_warn_reg <= 1'b0;
			pin_warn_reg  <= 1'b0;
		end else begin
			if (pd_active && pd_ms >= lin_ms(toff_lim_reg))
				toff_warn_reg <= 1'b1; // RL10
			else if (clr_cmd)
				toff_warn_reg <= 1'b0;
			if (lin_q8(pout_meas) > lin_q8(pout_thr_reg))
				pout_warn_reg <= 1'b1; // RL11
			else if (clr_cmd)
				pout_warn_reg <= 1'b0;
			if (lin_q8(pin_meas) > lin_q8(pin_thr_reg))
				pin_warn_reg <= 1'b1; // RL12
			else if (clr_cmd)
				pin_warn_reg <= 1'b0;
		end
	end
endmodule : frt_seq

// file: frt_seq_monitor.sv
`timescale 1ns/10ps
module frt_seq_monitor
	import frt_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// command port
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [7:0]  cmd_code,
	input wire logic        rsp_valid_reg,
	input wire logic        rsp_nack_reg,
	input wire logic [15:0] rsp_rdata_reg,
	// converter flags
	input wire logic        out_en_reg,
	input wire logic        fall_active_reg,
	input wire logic        retry_wait_reg,
	input wire logic        fault_latched_reg,
	input wire logic        toff_warn_reg,
	input wire logic        pout_warn_reg,
	input wire logic        pin_warn_reg
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic cmd_map;
	logic clr_cmd;
	assign clr_cmd = cmd_valid && cmd_write && cmd_code == CMD_FAULT_CLEAR;
	assign cmd_map = cmd_code inside {CMD_TON_FAULT_ACT, CMD_TOFF_DELAY,
		CMD_TOFF_FALL, CMD_TOFF_WARN_LIM, CMD_POUT_WARN, CMD_PIN_WARN,
		CMD_TIME_UNIT} || (cmd_write && cmd_code == CMD_FAULT_CLEAR);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_rsp_one_later: assert property (cmd_valid |=> rsp_valid_reg)
		else $error("no answer one cycle after a command");
	a_rsp_has_cause: assert property (rsp_valid_reg |-> $past(cmd_valid))
		else $error("answer without a command");
	a_nack_unmapped: assert property (cmd_valid && !cmd_map |=> rsp_nack_reg)
		else $error("unmapped code not refused");
	a_ack_mapped: assert property (cmd_valid && cmd_map |=> !rsp_nack_reg)
		else $error("mapped code refused");
	// read data moves only in the sample after a read
	a_rdata_holds: assert property (!(cmd_valid && !cmd_write) |=> $stable(rsp_rdata_reg))
		else $error("read data moved without a read");
	a_retry_is_off: assert property (retry_wait_reg |-> !out_en_reg)
		else $error("output on while waiting to restart");
	a_latch_is_off: assert property (fault_latched_reg |-> !out_en_reg && !fall_active_reg)
		else $error("output on while latched off");
	a_fall_while_on: assert property (fall_active_reg |-> out_en_reg)
		else $error("fall without output enabled");
	a_clear_unlatch: assert property (clr_cmd |-> ##[1:2] !fault_latched_reg)
		else $error("clear command left latch set");
	a_pout_sticky: assert property (pout_warn_reg && !clr_cmd |=> pout_warn_reg)
		else $error("output power warning dropped");
	a_pin_sticky: assert property (pin_warn_reg && !clr_cmd |=> pin_warn_reg)
		else $error("input power warning dropped");
	a_toff_sticky: assert property (toff_warn_reg && !clr_cmd |=> toff_warn_reg)
		else $error("turn-off warning dropped");
endmodule : frt_seq_monitor

bind frt_seq frt_seq_monitor #(.CYC_MS(CYC_MS)) u_mon (.clk, .arst_n,
	.cmd_valid, .cmd_write, .cmd_code, .rsp_valid_reg, .rsp_nack_reg,
	.rsp_rdata_reg, .out_en_reg, .fall_active_reg, .retry_wait_reg,
	.fault_latched_reg, .toff_warn_reg, .pout_warn_reg, .pin_warn_reg);

// file: frt_host.sv
`timescale 1ns/10ps
module frt_host (
	// clock
	input  wire logic        clk,
	// command port
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [15:0]      cmd_wdata,
	input  wire logic        rsp_valid_reg,
	input  wire logic        rsp_nack_reg,
	input  wire logic [15:0] rsp_rdata_reg
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// ----------------------------------------------------------------
	// one command; answer taken at the edge after
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] data, output logic [15:0] rd, output logic nk);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code  = code;
		cmd_wdata = data;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		// released data changes so a stale value never passes
		cmd_wdata = ~data;
		rd = rsp_rdata_reg;
		// a missing answer fails every refusal check
		nk = (rsp_valid_reg === 1'b1) ? rsp_nack_reg : 1'bx;
	endtask : xfer
endmodule : frt_host

// file: fault_retry_and_turnoff_sequencing_bench.sv
`timescale 1ns/10ps
module fault_retry_and_turnoff_sequencing_bench
	import frt_pkg::*;
;
	localparam int MS  = 20;
	localparam int LIM = 8000;
	typedef struct {
		logic [7:0]  code;
		logic [15:0] wd;
		logic [15:0] rd;
		logic        wn;
		logic        rn;
	} frt_row_t;
	frt_row_t rows [9] = '{
		'{CMD_TOFF_DELAY, 16'h1234, 16'h1234, 1'b0, 1'b0},
		'{CMD_TOFF_FALL, 16'habcd, 16'habcd, 1'b0, 1'b0},
		'{CMD_TOFF_WARN_LIM, 16'hffff, 16'hffff, 1'b0, 1'b0},
		'{CMD_POUT_WARN, 16'h8001, 16'h8001, 1'b0, 1'b0},
		'{CMD_PIN_WARN, 16'h5a5a, 16'h5a5a, 1'b0, 1'b0},
		'{CMD_TON_FAULT_ACT, 16'hab12, 16'h0012, 1'b0, 1'b0},
		'{CMD_TIME_UNIT, 16'h77c3, 16'h00c3, 1'b0, 1'b0},
		'{8'h70, 16'h1111, 16'h0000, 1'b1, 1'b1},
		'{CMD_FAULT_CLEAR, 16'h2222, 16'h0000, 1'b0, 1'b1}};
	logic        clk, arst_n, cmd_valid, cmd_write;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, rsp_rdata_reg, rd;
	logic        rsp_valid_reg, rsp_nack_reg, nk;
	logic        ctrl_pin, op_on, ton_fault_pin, other_fault_pin;
	logic [15:0] vout_set, vout_meas, pout_meas, pin_meas;
	logic        out_en_reg, fall_active_reg, retry_wait_reg;
	logic        fault_latched_reg, toff_warn_reg, pout_warn_reg;
	logic        pin_warn_reg;
	int          error_cnt, compares, t;

	frt_seq #(.CYC_MS(MS)) dut (.clk, .arst_n, .cmd_valid, .cmd_write,
		.cmd_code, .cmd_wdata, .rsp_valid_reg, .rsp_nack_reg, .rsp_rdata_reg,
		.ctrl_pin, .op_on, .ton_fault_pin, .other_fault_pin, .vout_set,
		.vout_meas, .pout_meas, .pin_meas, .out_en_reg, .fall_active_reg,
		.retry_wait_reg, .fault_latched_reg, .toff_warn_reg, .pout_warn_reg,
		.pin_warn_reg);
	frt_host host (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
		.rsp_valid_reg, .rsp_nack_reg, .rsp_rdata_reg);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk

	function automatic logic pick(input int s);
		case (s)
			0: pick = out_en_reg;
			1: pick = fall_active_reg;
			2: pick = fault_latched_reg;
			default: pick = retry_wait_reg;
		endcase
	endfunction : pick

	task automatic wait_lvl(input int s, input logic v, output int n);
		n = 0;
		while (pick(s) !== v && n < LIM) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= LIM) begin
			chk(1'b0, "wait expired");
			stop_test();
		end
	endtask : wait_lvl

	task automatic do_reset;
		arst_n = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		arst_n = 1'b1;
	endtask : do_reset

	// fault held high so every restart fails again
	task automatic run_retry(input logic [2:0] rc, input logic [2:0] tc,
		input logic [7:0] u, input int n, input logic lat);
		int k, gap, last, tt, e;
		logic pe;
		host.xfer(1'b1, CMD_TIME_UNIT, {8'h00, u}, rd, nk);
		host.xfer(1'b1, CMD_TON_FAULT_ACT, {8'h00, RESP_DISABLE_RETRY, rc, tc}, rd, nk);
		ctrl_pin = 1'b1;
		op_on = 1'b1;
		wait_lvl(0, 1'b1, tt);
		ton_fault_pin = 1'b1;
		wait_lvl(0, 1'b0, tt);
		pe = retry_wait_reg | fault_latched_reg;
		chk(tt <= 8 && pe === 1'b1, "slow shutdown");
		k = 0;
		gap = 0;
		last = 0;
		pe = 1'b0;
		tt = 0;
		while (fault_latched_reg !== 1'b1 && tt < LIM && (lat || k < n)) begin
			@(posedge clk);
			#1;
			tt++;
			gap++;
			if (out_en_reg === 1'b1 && !pe) begin
				k++;
				last = gap;
				gap = 0;
			end
			pe = out_en_reg;
		end
		chk(k == n && fault_latched_reg === lat, "restart count");
		e = (1 << tc) * u * MS;
		if (!lat) begin
			chk(last >= e - MS - 8 && last <= e + MS + 8, "spacing");
			other_fault_pin = 1'b1;
			k = 0;
			repeat (2 * e) begin
				@(posedge clk);
				#1;
				k += out_en_reg;
			end
			chk(k == 0, "restart after other fault");
		end
		ton_fault_pin = 1'b0;
		other_fault_pin = 1'b0;
		// latch is cleared by the pin toggle, forever case by command off
		if (lat)
			ctrl_pin = 1'b0;
		else
			op_on = 1'b0;
		wait_lvl(2, 1'b0, tt);
		wait_lvl(3, 1'b0, tt);
		chk(out_en_reg === 1'b0, "still on after off");
		$display("retry code %0d done", rc);
	endtask : run_retry

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		{error_cnt, compares} = '0;
		{ctrl_pin, op_on, ton_fault_pin, other_fault_pin} = '0;
		vout_set = 16'h0010;
		vout_meas = 16'h0010;
		{pout_meas, pin_meas} = '0;
		do_reset();
		foreach (rows[i]) begin
			host.xfer(1'b1, rows[i].code, rows[i].wd, rd, nk);
			chk(nk === rows[i].wn, "write refusal");
			host.xfer(1'b0, rows[i].code, 16'h0000, rd, nk);
			chk(nk === rows[i].rn, "read refusal");
			if (!rows[i].rn)
				chk(rd === rows[i].rd, "read back");
		end
		$display("register rows done");
		do_reset();
		chk({out_en_reg, fault_latched_reg, rsp_valid_reg} === 3'h0, "reset");
		for (int i = 0; i < 7; i++) begin
			host.xfer(1'b0, rows[i].code, 16'h0000, rd, nk);
			chk(rd === ((rows[i].code == CMD_TIME_UNIT) ? RST_TIME_UNIT : RST_WORD), "reset value");
		end
		$display("reset values done");
		for (int r = 4; r < 7; r++)
			run_retry(3'(r), 3'h0, 8'h01, r, 1'b1);
		run_retry(RETRY_NONE, 3'h1, 8'h01, 0, 1'b1);
		run_retry(RETRY_FOREVER, 3'h3, 8'h02, 4, 1'b0);
		run_retry(RETRY_FOREVER, 3'h7, 8'h01, 2, 1'b0);
		host.xfer(1'b1, CMD_TON_FAULT_ACT, 16'h0000, rd, nk);
		op_on = 1'b1;
		wait_lvl(0, 1'b1, t);
		ton_fault_pin = 1'b1;
		repeat (3 * MS) @(posedge clk);
		#1;
		chk(out_en_reg === 1'b1 && retry_wait_reg === 1'b0, "ignore");
		ton_fault_pin = 1'b0;
		host.xfer(1'b1, CMD_TON_FAULT_ACT,
			{8'h00, RESP_RUN_THEN_RETRY, 6'h01}, rd, nk);
		repeat (8) @(posedge clk);
		#1;
		ton_fault_pin = 1'b1;
		wait_lvl(2, 1'b1, t);
		chk(t >= MS && t <= 2 * MS + 8, "run-on time");
		ton_fault_pin = 1'b0;
		op_on = 1'b0;
		wait_lvl(2, 1'b0, t);
		$display("run-on response done");
		host.xfer(1'b1, CMD_TON_FAULT_ACT, {RESP_LATCH_OFF, 6'h00}, rd, nk);
		ctrl_pin = 1'b1;
		op_on = 1'b1;
		wait_lvl(0, 1'b1, t);
		ton_fault_pin = 1'b1;
		wait_lvl(2, 1'b1, t);
		ton_fault_pin = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk(fault_latched_reg === 1'b1, "latch lost");
		host.xfer(1'b1, CMD_FAULT_CLEAR, 16'h0000, rd, nk);
		wait_lvl(2, 1'b0, t);
		wait_lvl(0, 1'b1, t);
		$display("clear command done");
		host.xfer(1'b1, CMD_TOFF_DELAY, 16'h0801, rd, nk);
		host.xfer(1'b1, CMD_TOFF_FALL, 16'hf808, rd, nk);
		host.xfer(1'b1, CMD_TOFF_WARN_LIM, 16'h0000, rd, nk);
		op_on = 1'b0;
		wait_lvl(1, 1'b1, t);
		chk(t >= MS && t <= 3 * MS + 8 && out_en_reg === 1'b1, "delay");
		wait_lvl(1, 1'b0, t);
		chk(t >= 3 * MS - 8 && t <= 5 * MS + 8, "fall time");
		chk(out_en_reg === 1'b0, "on after fall");
		chk(toff_warn_reg === 1'b1, "turn-off warning");
		$display("turn-off done");
		host.xfer(1'b1, CMD_POUT_WARN, 16'h0064, rd, nk);
		host.xfer(1'b1, CMD_PIN_WARN, 16'h0064, rd, nk);
		pout_meas = 16'h0064;
		pin_meas = 16'h0064;
		repeat (4) @(posedge clk);
		#1;
		chk({pout_warn_reg, pin_warn_reg} === 2'b00, "warn at limit");
		pout_meas = 16'h0065;
		repeat (4) @(posedge clk);
		#1;
		chk({pout_warn_reg, pin_warn_reg} === 2'b10, "output power");
		pin_meas = 16'h0065;
		repeat (4) @(posedge clk);
		#1;
		chk(pin_warn_reg === 1'b1, "input power");
		$display("power warnings done");
		stop_test();
	end
endmodule : fault_retry_and_turnoff_sequencing_bench
